// *** src/mpeg_tc_regs.svh ***
// Byte values, field positions and counts of the downstream transport framing.
// Assumes inclusion by the package and by every design module.
`ifndef MPEG_TC_REGS_SVH
`define MPEG_TC_REGS_SVH

// Transport packet layout.
`define TC_PKT_LAST 8'hBB
`define TC_PAY_LEN 8'hB8
`define TC_POS_PID_HI 8'h01
`define TC_POS_PID_LO 8'h02
`define TC_POS_CTRL 8'h03
`define TC_POS_PTR 8'h04
`define TC_PKT_LEN 8'hBC

// Header field values.
`define TC_SYNC 8'h47
`define TC_FILL 8'hFF
`define TC_PID_MAC 13'h1FFE
`define TC_PID_NULL 13'h1FFF
`define TC_AFC_PAYLOAD 2'h1

// Alignment tracking counts.
`define TC_LOCK_GOOD 3'h5
`define TC_LOSS_BAD 4'h9

`endif

// *** src/mpeg_tc_pkg.sv ***
// Types and shared decoding for the transport convergence block.
// Assumes the constant header is on the include path.
`include "mpeg_tc_regs.svh"

package mpeg_tc_pkg;

    typedef enum logic [3:0] {
        TX_HDR = 4'h1,
        TX_PTR = 4'h2,
        TX_PAY = 4'h4,
        TX_NULL = 4'h8
    } tx_state_type;

    typedef enum logic [3:0] {
        RX_WAIT = 4'h1,
        RX_SKIP = 4'h2,
        RX_HUNT = 4'h4,
        RX_FRAME = 4'h8
    } rx_state_type;

    // A byte equal to the fill value can never open a frame.
    function automatic logic is_fill(input logic [7:0] b);
        is_fill = (b == `TC_FILL);
    endfunction : is_fill

endpackage : mpeg_tc_pkg

// *** src/mpeg_tc_hdr.sv ***
// Header byte builder with the continuity counter of the cable data stream.
// Assumes the packer steps it once per cable data packet, same clock.
`timescale 1ns/1ps
`include "mpeg_tc_regs.svh"

module mpeg_tc_hdr (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [1:0] i_idx,
    input wire logic i_pusi,
    input wire logic i_null,
    input wire logic i_step,
    output logic [7:0] o_byte
);
    import mpeg_tc_pkg::*;

    typedef struct packed {
        logic [3:0] cc;
    } hdr_reg_type;

    hdr_reg_type hdr_q;
    hdr_reg_type hdr_d;
    logic [12:0] pid;

    // Counter advances per cable data packet and wraps after 15.
    always_comb
    begin
        hdr_d = hdr_q;
        if (i_step)
        begin
            hdr_d.cc = hdr_q.cc + 4'h1; // [R04]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            hdr_q <= '0;
        else
            hdr_q <= hdr_d;
    end

    // Header bytes one to three; null packets carry their own identifier.
    assign pid = i_null ? `TC_PID_NULL : `TC_PID_MAC; // [R03]
    always_comb
    begin
        case (i_idx)
            2'h1: o_byte = {1'b0, i_pusi, 1'b0, pid[12:8]};
            2'h2: o_byte = pid[7:0];
            2'h3: o_byte = {2'h0, `TC_AFC_PAYLOAD, i_null ? 4'h0 : hdr_q.cc};
            default: o_byte = `TC_SYNC;
        endcase
    end

    a_cc_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_step && hdr_q.cc == 4'hF) |=> (hdr_q.cc == 4'h0)) // [R04]
        else $error("Continuity counter did not wrap to zero.");

endmodule : mpeg_tc_hdr

// *** src/mpeg_tc_align.sv ***
// Packet alignment tracker driven by per-packet parity checksum results.
// Assumes the physical decoder reports one result per received packet.
`timescale 1ns/1ps
`include "mpeg_tc_regs.svh"

module mpeg_tc_align #(
    parameter logic [2:0] LOCK_GOOD = `TC_LOCK_GOOD,
    parameter logic [3:0] LOSS_BAD = `TC_LOSS_BAD
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_byte,
    input wire logic i_chk_valid,
    input wire logic i_chk_good,
    output logic o_in_frame
);
    import mpeg_tc_pkg::*;

    typedef struct packed {
        logic in_frame;
        logic [2:0] good;
        logic [3:0] bad;
        logic [7:0] gap;
    } align_reg_type;

    align_reg_type al_q;
    align_reg_type al_d;
    logic [7:0] gap_now;
    logic spaced;

    // Bytes counted since the previous checksum, this cycle's byte included.
    assign gap_now = (i_byte && al_q.gap != 8'hFF) ? al_q.gap + 8'h01 : al_q.gap;
    assign spaced = (gap_now == `TC_PKT_LEN);

    // Lock after consecutive good spaced checksums, lose after bad ones.
    always_comb
    begin
        al_d = al_q;
        al_d.gap = gap_now;
        if (i_chk_valid)
        begin
            al_d.gap = 8'h00;
            if (!al_q.in_frame)
            begin
                if (!i_chk_good)
                    al_d.good = 3'h0;
                else if (spaced || al_q.good == 3'h0)
                    al_d.good = al_q.good + 3'h1;
                else
                    al_d.good = 3'h1;
                if (i_chk_good && (spaced || al_q.good == 3'h0)
                    && al_q.good + 3'h1 == LOCK_GOOD)
                begin
                    al_d.in_frame = 1'b1; // [R19]
                    al_d.bad = 4'h0;
                end
            end
            else if (i_chk_good)
                al_d.bad = 4'h0;
            else if (al_q.bad + 4'h1 == LOSS_BAD)
            begin
                al_d.in_frame = 1'b0; // [R20]
                al_d.good = 3'h0;
                al_d.bad = 4'h0;
            end
            else
                al_d.bad = al_q.bad + 4'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            al_q <= '0;
        else
            al_q <= al_d;
    end

    assign o_in_frame = al_q.in_frame;

    a_lock_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_in_frame) |-> $past(i_chk_valid && i_chk_good && al_q.good == 3'h4)) // [R19]
        else $error("Alignment declared without five good checksums.");

    a_loss_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $fell(o_in_frame) |-> $past(i_chk_valid && !i_chk_good && al_q.bad == 4'h8)) // [R20]
        else $error("Alignment lost without nine bad checksums.");

endmodule : mpeg_tc_align

// *** src/mpeg_tc_top.sv ***
// Downstream transport convergence: head-end packer and modem decoder.
// Assumes MAC logic and the physical coder share i_clk_sys; byte strobes
// from the coder arrive at least two cycles apart.
`timescale 1ns/1ps
`include "mpeg_tc_regs.svh"

// Operation
// R01: Every packet is 188 bytes, header of four plus 184 payload, back to back.
// R02: First header byte of every packet is the sync value 0x47.
// R03: Cable data packets carry the reserved 13-bit identifier 0x1FFE.
// R04: Four-bit continuity counter steps for each cable data packet.
// R05: Payload gaps between frames are filled with 0xFF bytes.
// R06: A frame control byte of 0xFF is never sent nor taken as a start.
// R07: Start flag set means byte five is the pointer byte.
// R08: Decoder skips exactly pointer-many bytes after the pointer before searching.
// R09: Packer sets the start flag wherever a frame could begin in the packet.
// R10: Pointer addresses the first new frame or a fill byte before it.
// R11: Frames start anywhere, span packets, and share packets with others.
// R12: Pointer zero means searching starts right after the pointer byte.
// R13: Frames in a packet sit back to back or with any fill between.
// R14: Continuation packets have the start flag clear and 184 frame bytes.
// R15: After header and pointer, a late frame may follow fill in that packet.
// R16: Send null packets instead of cable packets holding only fill.
// R17: Fixed byte timing keeps MAC timestamps accurate.
// R18: Packet stream goes to the coder, which adds per-packet parity.
// R19: In frame after five good checksums each 188 bytes apart.
// R20: Out of frame and new search after nine bad checksums.
// R21: While searching, fill bytes are dropped; first other byte is frame control.
module mpeg_tc_top #(
    parameter int LEN_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [7:0] i_frm_data,
    input wire logic i_frm_valid,
    input wire logic i_frm_first,
    input wire logic [LEN_W-1:0] i_frm_len,
    output logic o_frm_ack,
    output logic o_frm_drop,
    input wire logic i_ts_strobe,
    output logic [7:0] o_ts_data,
    output logic o_ts_valid,
    output logic o_ts_sop,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_valid,
    input wire logic i_rx_sop,
    input wire logic i_chk_valid,
    input wire logic i_chk_good,
    input wire logic i_mac_end,
    output logic [7:0] o_mac_data,
    output logic o_mac_valid,
    output logic o_mac_first,
    output logic o_in_frame
);
    import mpeg_tc_pkg::*;

    typedef struct packed {
        tx_state_type st;
        logic [7:0] pos;
        logic [LEN_W-1:0] rem;
        logic pusi;
        logic null_pkt;
        logic [7:0] ptr;
        logic [7:0] data;
        logic valid;
        logic sop;
        logic ack;
        logic drop;
    } tx_reg_type;

    typedef struct packed {
        rx_state_type st;
        logic [7:0] pos;
        logic ours;
        logic pusi;
        logic [7:0] skip;
        logic tail;
        logic [7:0] data;
        logic valid;
        logic first;
    } rx_reg_type;

    localparam tx_reg_type TX_RESET = '{st: TX_HDR, default: '0};
    localparam rx_reg_type RX_RESET = '{st: RX_WAIT, default: '0};
    // Named copy of the cable identifier so that its bytes can be sliced.
    localparam logic [12:0] PID_MAC = `TC_PID_MAC;

    tx_reg_type tx_q;
    tx_reg_type tx_d;
    rx_reg_type rx_q;
    rx_reg_type rx_d;
    logic [7:0] hdr_byte;
    logic cc_step;
    logic in_frame;
    logic [7:0] rx_p;
    logic [7:0] a_cnt_q;
    logic a_seen_q;

    // Header bytes one to three and the continuity counter.
    mpeg_tc_hdr mpeg_tc_hdr_i (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_idx(tx_q.pos[1:0]),
        .i_pusi(tx_q.pusi),
        .i_null(tx_q.null_pkt),
        .i_step(cc_step),
        .o_byte(hdr_byte)
    );

    // Receive alignment from the coder's per-packet checksum results.
    mpeg_tc_align mpeg_tc_align_i (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_byte(i_rx_valid),
        .i_chk_valid(i_chk_valid),
        .i_chk_good(i_chk_good),
        .o_in_frame(in_frame)
    );

    // Packer: one output byte per strobe, the packet position free-running,
    // so the byte stream never pauses and frame byte latency is fixed.
    always_comb
    begin
        tx_d = tx_q;
        tx_d.valid = 1'b0;
        tx_d.ack = 1'b0;
        tx_d.drop = 1'b0;
        cc_step = 1'b0;
        if (i_ts_strobe)
        begin
            tx_d.valid = 1'b1; // [R18]
            tx_d.sop = (tx_q.pos == 8'h00);
            tx_d.pos = (tx_q.pos == `TC_PKT_LAST) ? 8'h00 : tx_q.pos + 8'h01; // [R01]
            tx_d.data = `TC_FILL;
            case (tx_q.st)
                TX_HDR:
                begin
                    if (tx_q.pos == 8'h00)
                    begin
                        tx_d.data = `TC_SYNC; // [R02]
                        // Idle with nothing waiting: only fill would follow.
                        tx_d.null_pkt = (tx_q.rem == '0) && !i_frm_valid; // [R16]
                        // Only a frame filling the whole payload suppresses the pointer.
                        tx_d.pusi = (tx_q.rem < LEN_W'(`TC_PAY_LEN)); // [R09] [R14]
                        // Pointer covers the tail, landing just past it.
                        tx_d.ptr = tx_q.rem[7:0]; // [R10]
                    end
                    else
                    begin
                        tx_d.data = hdr_byte; // [R03]
                        if (tx_q.pos == `TC_POS_CTRL)
                        begin
                            cc_step = !tx_q.null_pkt; // [R04]
                            if (tx_q.null_pkt)
                                tx_d.st = TX_NULL;
                            else if (tx_q.pusi)
                                tx_d.st = TX_PTR; // [R07]
                            else
                                tx_d.st = TX_PAY;
                        end
                    end
                end
                TX_PTR:
                begin
                    tx_d.data = tx_q.ptr; // [R07]
                    tx_d.st = TX_PAY;
                end
                TX_NULL:
                begin
                    if (tx_q.pos == `TC_PKT_LAST)
                        tx_d.st = TX_HDR;
                end
                TX_PAY:
                begin
                    if (tx_q.rem != '0)
                    begin
                        // Frame body and tails run across packet edges.
                        if (i_frm_valid)
                        begin
                            tx_d.data = i_frm_data; // [R11]
                            tx_d.ack = 1'b1;
                            tx_d.rem = tx_q.rem - LEN_W'(1);
                        end
                    end
                    else if (i_frm_valid && i_frm_first)
                    begin
                        // A new frame starts on any payload byte unless its first byte is the fill value.
                        tx_d.ack = 1'b1;
                        if (is_fill(i_frm_data))
                            tx_d.drop = 1'b1; // [R06]
                        else
                        begin
                            tx_d.data = i_frm_data; // [R13] [R15]
                            tx_d.rem = i_frm_len - LEN_W'(1);
                        end
                    end
                    // Otherwise the gap is filled. [R05]
                    if (tx_q.pos == `TC_PKT_LAST)
                        tx_d.st = TX_HDR;
                end
                default:
                begin
                    tx_d.st = TX_HDR;
                end
            endcase
        end
    end

    // Decoder position within the received packet.
    assign rx_p = i_rx_sop ? 8'h00 : rx_q.pos;

    // Decoder: checks the header, honours the pointer, hunts frame starts.
    always_comb
    begin
        rx_d = rx_q;
        rx_d.valid = 1'b0;
        rx_d.first = 1'b0;
        if (!in_frame)
            rx_d.st = RX_WAIT; // [R20]
        else
        begin
            // The MAC side knows the frame length and reports its end.
            if (i_mac_end)
            begin
                rx_d.tail = 1'b0;
                if (rx_q.st == RX_FRAME)
                    rx_d.st = RX_HUNT;
            end
            if (i_rx_valid)
            begin
                rx_d.pos = rx_p + 8'h01;
                rx_d.data = i_rx_data;
                if (rx_p == 8'h00)
                    rx_d.ours = (i_rx_data == `TC_SYNC); // [R02]
                else if (rx_p == `TC_POS_PID_HI)
                begin
                    rx_d.ours = rx_q.ours && !i_rx_data[7]
                        && (i_rx_data[4:0] == PID_MAC[12:8]);
                    rx_d.pusi = i_rx_data[6];
                end
                else if (rx_p == `TC_POS_PID_LO)
                    rx_d.ours = rx_q.ours && (i_rx_data == PID_MAC[7:0]); // [R03]
                else if (rx_p == `TC_POS_CTRL)
                    rx_d.ours = rx_q.ours && (i_rx_data[5:4] == `TC_AFC_PAYLOAD);
                else if (rx_q.ours)
                begin
                    if (rx_p == `TC_POS_PTR && rx_q.pusi)
                    begin
                        // Pointer byte: the tail bytes before the search point
                        // still belong to a frame being delivered.
                        rx_d.skip = i_rx_data; // [R07] [R08]
                        rx_d.tail = (rx_d.st == RX_FRAME);
                        rx_d.st = (i_rx_data == 8'h00) ? RX_HUNT : RX_SKIP; // [R12]
                    end
                    else
                    begin
                        case (rx_d.st)
                            RX_SKIP:
                            begin
                                rx_d.valid = rx_d.tail;
                                rx_d.skip = rx_q.skip - 8'h01;
                                if (rx_q.skip == 8'h01)
                                    rx_d.st = RX_HUNT; // [R08]
                            end
                            RX_HUNT:
                            begin
                                if (!is_fill(i_rx_data))
                                begin
                                    rx_d.valid = 1'b1; // [R21] [R06]
                                    rx_d.first = 1'b1;
                                    rx_d.st = RX_FRAME;
                                end
                            end
                            RX_FRAME:
                            begin
                                rx_d.valid = 1'b1; // [R11]
                            end
                            default:
                            begin
                                rx_d.valid = 1'b0;
                            end
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_q <= TX_RESET;
            rx_q <= RX_RESET;
        end
        else
        begin
            tx_q <= tx_d;
            rx_q <= rx_d;
        end
    end

    // Every output is a flip-flop of the two state records or the tracker.
    assign o_frm_ack = tx_q.ack; // [R17]
    assign o_frm_drop = tx_q.drop;
    assign o_ts_data = tx_q.data;
    assign o_ts_valid = tx_q.valid;
    assign o_ts_sop = tx_q.sop;
    assign o_mac_data = rx_q.data;
    assign o_mac_valid = rx_q.valid;
    assign o_mac_first = rx_q.first;
    assign o_in_frame = in_frame;

    // Helper: output bytes counted from each packet start.
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            a_cnt_q <= 8'h00;
            a_seen_q <= 1'b0;
        end
        else if (o_ts_valid)
        begin
            a_cnt_q <= o_ts_sop ? 8'h01 : a_cnt_q + 8'h01;
            a_seen_q <= a_seen_q | o_ts_sop;
        end
    end

    a_pkt_length: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_ts_valid && o_ts_sop && a_seen_q) |-> (a_cnt_q == `TC_PKT_LEN)) // [R01]
        else $error("Transport packet length is not 188 bytes.");

    a_sync_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_ts_valid && o_ts_sop) |-> (o_ts_data == `TC_SYNC)) // [R02]
        else $error("Packet does not open with the sync byte.");

    a_pid_low: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_ts_valid && tx_q.pos == `TC_POS_CTRL && !tx_q.null_pkt)
        |-> (o_ts_data == PID_MAC[7:0])) // [R03]
        else $error("Cable data packet carries a wrong identifier.");

    a_null_fill: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_ts_valid && tx_q.null_pkt && tx_q.pos > `TC_POS_PTR) |-> (o_ts_data == `TC_FILL)) // [R05]
        else $error("Null packet payload is not fill.");

    a_ptr_place: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_ts_valid && tx_q.pos == 8'h05 && tx_q.pusi && !tx_q.null_pkt)
        |-> (o_ts_data == tx_q.ptr)) // [R07]
        else $error("Pointer byte is not the fifth packet byte.");

    a_no_fill_start: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_mac_valid && o_mac_first) |-> (o_mac_data != `TC_FILL)) // [R06]
        else $error("Fill value delivered as a frame start.");

    a_ptr_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (in_frame && i_rx_valid && !i_rx_sop && rx_q.pos == `TC_POS_PTR && rx_q.ours
        && rx_q.pusi && i_rx_data == 8'h00) |=> (rx_q.st == RX_HUNT)) // [R12]
        else $error("Zero pointer did not start the search.");

    a_hunt_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (in_frame && i_rx_valid && !i_rx_sop && rx_q.pos > `TC_POS_PTR && rx_q.ours
        && rx_q.st == RX_HUNT && i_rx_data == `TC_FILL && !i_mac_end) |=> !o_mac_valid) // [R21]
        else $error("Fill byte delivered while searching.");

endmodule : mpeg_tc_top

// *** tb/mac_src_model.sv ***
// MAC frame source that feeds whole frames to the packer.
// Assumes the bench queues frames by send and reads the notes in exp_q.
`timescale 1ns/1ps
module mac_src_model (
    input wire logic i_clk_sys,
    input wire logic i_ack,
    output logic [7:0] o_data,
    output logic o_valid,
    output logic o_first,
    output logic [15:0] o_len
);
    logic [7:0] bq[$];
    logic fq[$];
    logic [15:0] lq[$];
    logic [9:0] exp_q[$];

    // Lines start idle.
    initial
    begin
        o_data = 8'h00;
        o_valid = 1'b0;
        o_first = 1'b0;
        o_len = 16'h0000;
    end

    // Queues a frame whole, so no gap opens inside it; notes what the sink gets.
    task automatic send(input int n, input logic [7:0] fc);
        logic [7:0] b;
        for (int k = 0; k < n; k++)
        begin
            b = (k == 0) ? fc : 8'($urandom);
            bq.push_back(b);
            fq.push_back(k == 0);
            lq.push_back(16'(n));
            if (fc != 8'hFF)
                exp_q.push_back({k == n - 1, k == 0, b});
        end
    endtask : send

    // A byte stays offered until acked; idle data and length lines show the inverse of the last value.
    always @(posedge i_clk_sys)
    begin
        if (i_ack)
        begin
            void'(bq.pop_front());
            void'(fq.pop_front());
            void'(lq.pop_front());
        end
        o_valid <= (bq.size() != 0);
        o_data <= (bq.size() != 0) ? bq[0] : ~o_data;
        o_first <= (fq.size() != 0) && fq[0];
        o_len <= (lq.size() != 0) ? lq[0] : ~o_len;
    end
endmodule : mac_src_model

// *** tb/mpeg_mac_frame_convergence_tb.sv ***
// Bench for the convergence block with the packer looped into the decoder.
// Assumes the design sources and the MAC source model compile first.
`timescale 1ns/1ps
module mpeg_mac_frame_convergence_tb;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic i_ts_strobe = 1'b0;
    logic i_mac_end = 1'b0;
    logic bad = 1'b0;
    logic [7:0] frm_data, ts_data, mac_data, h1, h2;
    logic [15:0] frm_len;
    logic frm_valid, frm_first, ack, drop, ts_valid, ts_sop, mac_valid, mac_first, in_frame;
    logic [9:0] e;
    logic [3:0] cc = 4'h0;
    int num_errors = 0;
    int samples_checked = 0;
    int chk_n = 0;
    int chk_base = 0;
    int drops = 0;
    int cable = 0;
    int pos = -1;
    int sc = 0;

    always #2 i_clk_sys = ~i_clk_sys;

    mpeg_tc_top #(.LEN_W(16)) mpeg_tc_top_i (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_frm_data(frm_data),
        .i_frm_valid(frm_valid), .i_frm_first(frm_first), .i_frm_len(frm_len),
        .o_frm_ack(ack), .o_frm_drop(drop), .i_ts_strobe(i_ts_strobe),
        .o_ts_data(ts_data), .o_ts_valid(ts_valid), .o_ts_sop(ts_sop),
        .i_rx_data(ts_data), .i_rx_valid(ts_valid), .i_rx_sop(ts_sop),
        .i_chk_valid(ts_valid & ts_sop), .i_chk_good(~bad), .i_mac_end(i_mac_end),
        .o_mac_data(mac_data), .o_mac_valid(mac_valid), .o_mac_first(mac_first),
        .o_in_frame(in_frame));

    mac_src_model mac_src_model_i (
        .i_clk_sys(i_clk_sys), .i_ack(ack), .o_data(frm_data),
        .o_valid(frm_valid), .o_first(frm_first), .o_len(frm_len));

    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : cmp

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // Waits for lock (0), loss (1) or an empty note queue (2), bounded.
    task automatic wait_for(input int n, input int sel);
        int k;
        k = 0;
        while (k < n && !(sel == 0 ? in_frame === 1'b1 : sel == 1 ? in_frame === 1'b0
                          : mac_src_model_i.exp_q.size() == 0))
        begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        if (k == n)
        begin
            num_errors++;
            $display("[ERR] %0t wait ran out", $time);
            end_sim();
        end
    endtask : wait_for

    // One byte request every third cycle, so the registered ack keeps up.
    always @(posedge i_clk_sys)
    begin
        sc <= (sc == 2) ? 0 : sc + 1;
        i_ts_strobe <= (sc == 0) && i_rstn;
        if (ts_valid && ts_sop)
            chk_n <= chk_n + 1;
    end

    // Checks the framing of every packet leaving the packer.
    always @(posedge i_clk_sys)
    begin
        if (ts_valid)
        begin
            if (ts_sop && pos >= 0)
                cmp(16'(pos), 16'd187);
            pos = ts_sop ? 0 : pos + 1;
            if (ts_sop)
                cmp(16'(ts_data), 16'h0047);
            if (pos == 1)
                h1 = ts_data;
            if (pos == 2)
                h2 = ts_data;
            if (pos == 3)
                cmp(16'({h1[4:0], h2} | 13'h0001), 16'h1FFF);
            if (pos == 3 && {h1[4:0], h2} == 13'h1FFE)
            begin
                cmp(16'({h1[7], h1[5], ts_data}), 16'({4'h1, cc}));
                cc++;
                cable++;
            end
        end
    end

    // Compares each delivered MAC byte with the oldest note and ends the frame.
    always @(posedge i_clk_sys)
    begin
        i_mac_end <= 1'b0;
        if (drop)
            drops++;
        if (ack)
            cmp(16'(ts_valid), 16'h0001);
        if (mac_valid && mac_src_model_i.exp_q.size() == 0)
        begin
            num_errors++;
            $display("[ERR] %0t byte delivered with no note", $time);
        end
        else if (mac_valid)
        begin
            e = mac_src_model_i.exp_q.pop_front();
            cmp(16'({mac_first, mac_data}), 16'(e[8:0]));
            i_mac_end <= e[9];
        end
    end

    initial
    begin
        void'($urandom(1017));
        repeat (16) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        #1;
        cmp(16'({in_frame, ts_valid, mac_valid, ack}), 16'h0000);
        wait_for(4000, 0);
        cmp(16'(chk_n), 16'd5);
        cmp(16'(cable), 16'd0);
        $display("test lock done");
        for (int f = 0; f < 8; f++)
            mac_src_model_i.send(1 + $urandom % 300, 8'($urandom % 255));
        mac_src_model_i.send(1, 8'hFF);
        mac_src_model_i.send(200, 8'h00);
        wait_for(20000, 2);
        repeat (3 + $urandom % 90) @(posedge i_clk_sys);
        mac_src_model_i.send(5, 8'h3C);
        wait_for(3000, 2);
        cmp(16'(drops), 16'd1);
        $display("test frames done");
        @(posedge i_clk_sys);
        bad <= 1'b1;
        #1;
        chk_base = chk_n;
        wait_for(7000, 1);
        cmp(16'(chk_n - chk_base), 16'd9);
        $display("test loss done");
        end_sim();
    end
endmodule : mpeg_mac_frame_convergence_tb
